// *** src/uar_pkg.sv ***
// shared constants, register map and types of the uart receive and break block
package uar_pkg;
  // register byte addresses, one aligned word each, data in the low byte
  localparam logic [4:0] ADR_STATUS = 5'h00;
  localparam logic [4:0] ADR_CTRL1 = 5'h04;
  localparam logic [4:0] ADR_CTRL2 = 5'h08;
  localparam logic [4:0] ADR_BAUD = 5'h0c;
  localparam logic [4:0] ADR_TXDATA = 5'h10;
  localparam logic [4:0] ADR_RXDATA = 5'h14;

  // uart_status_register bits
  localparam int ST_TX_BUFFER_EMPTY_FLAG = 0;
  localparam int ST_TRANSMITTER_IDLE_FLAG = 1;
  localparam int ST_RX_DATA_READY_FLAG = 2;
  localparam int ST_RECEIVER_IDLE_FLAG = 3;
  localparam int ST_OVERRUN_FLAG = 4;
  localparam int ST_FRAMING_ERROR_FLAG = 5;
  localparam int ST_NF = 6;
  localparam int ST_PARITY_ERROR_FLAG = 7;

  // uart_control_one bits
  localparam int C1_TX8 = 0;
  localparam int C1_RX8 = 1;
  localparam int C1_BRK = 2;
  localparam int C1_STOP2 = 3;
  localparam int C1_ODD = 4;
  localparam int C1_PREN = 5;
  localparam int C1_NINE = 6;
  localparam int C1_EN = 7;

  // second control register bits
  localparam int C2_TEIE = 0;
  localparam int C2_TIIE = 1;
  localparam int C2_RIE = 2;
  localparam int C2_RECEIVER_ENABLE = 6;
  localparam int C2_TXEN = 7;

  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;

  // sixteen ticks per bit; votes taken on ticks 7, 8 and 9 after the start edge
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] TICK_DECIDE = 4'h9;
  localparam logic [3:0] BITS8 = 4'h8;
  localparam logic [3:0] BITS9 = 4'h9;
  localparam logic [4:0] BREAK_LAST = 5'h0c;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [4:0] adr;
    logic [31:0] dat;
  } uar_wb_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } uar_wb_rsp_s;

  typedef struct packed {
    logic framing_error_flag;
    logic parity_error_flag;
    logic [8:0] data;
  } uar_entry_s;

  typedef enum logic [2:0] {
    RX_HUNT = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b011,
    RX_STOP = 3'b010,
    RX_WAIT = 3'b110
  } uar_rx_state_e;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b011,
    TX_STOP = 3'b010,
    TX_BRK = 3'b110
  } uar_tx_state_e;

  typedef struct packed {
    logic ack;
    logic [7:0] rdat;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] baud;
    logic seen;
    logic tx_buffer_empty_flag;
    logic transmitter_idle_flag;
    logic [8:0] txbuf;
    logic rx_data_ready_flag;
    logic overrun_flag;
    logic nf;
    logic irq;
    logic [7:0] div;
    logic tick;
    uar_rx_state_e rx_st;
    logic [3:0] rx_cnt;
    logic [2:0] rx_smp;
    logic [3:0] rx_bits;
    logic [8:0] rx_sh;
    logic rx_noise;
    logic rx_framing_error_flag;
    logic rx_par;
    uar_entry_s [1:0] fifo;
    logic wp;
    logic rp;
    logic [1:0] cnt;
    uar_tx_state_e tx_st;
    logic [3:0] tx_cnt;
    logic [4:0] tx_bits;
    logic [8:0] tx_sh;
    logic tx_brk;
    logic tx_line;
  } uar_state_s;
endpackage

// *** src/uar_core.sv ***
// uart receiver with two-word fifo, break transmitter and wishbone register slave
`timescale 1ns/1ps

// How it works
// - status access then data write clears tx flags
// - send-break set makes next frame a break
// - break is start plus 13xN zeros, two_stop_select
// - break frames raise no transmit interrupt
// - break repeats while set, then stop bits
// - nine-bit mode puts top bit in control
// - sixteen ticks per bit, shifter per bit
// - each bit is a three-sample majority vote
// - data arrives least significant bit first
// - after stop sample, word enters fifo if room
// - fifo holds two; third on overrun is dropped
// - receiver enable starts the start-bit hunt
// - data ready set when fifo holds words
// - interrupt on each word moved, if enabled
// - overrun also interrupts when enabled
// - data ready cleared by status then read
// - frame errors set their flags when seen
// - break is framing error, fixed frame length
// - break completes: ready, framing, zeros, idle
// - after bad stop wait for high line
// - idle low from start to stop sample
// - overrun keeps fifo, flag cleared by sequence
// - any low stop bit flags framing, per word
module uar_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire uar_pkg::uar_wb_req_s wb_i,
  output uar_pkg::uar_wb_rsp_s wb_o,
  input wire logic rx_i,
  output logic tx_o,
  output logic irq_o
);
  import uar_pkg::*;

  uar_state_s s;
  uar_state_s next_s;
  uar_entry_s head;
  uar_entry_s entry;
  logic [7:0] status;
  logic [3:0] nbits;
  logic acc;
  logic wr;
  logic pop;
  logic push;
  logic full;
  logic decide;
  logic bitv;
  logic receiver_idle_flag;
  logic tx_end;
  logic rx_en;
  logic tx_en;

  function automatic logic uar_maj3(input logic [2:0] v);
    return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  // parity, when enabled, replaces the top bit of the word
  function automatic logic [8:0] uar_tx_word(input logic [8:0] buf_v, input logic [7:0] c1);
    logic [8:0] w;
    w = c1[C1_NINE] ? buf_v : {1'b0, buf_v[7:0]};
    if (c1[C1_PREN]) begin
      if (c1[C1_NINE]) begin
        w[8] = (^w[7:0]) ^ c1[C1_ODD];
      end else begin
        w[7] = (^w[6:0]) ^ c1[C1_ODD];
      end
    end
    return w;
  endfunction

  always_comb begin
    next_s = s;
    next_s.ack = 1'b0;
    next_s.irq = 1'b0;
    next_s.tick = (s.div == s.baud);
    next_s.div = next_s.tick ? 8'h00 : s.div + 8'h01;
    head = s.fifo[s.rp];
    receiver_idle_flag = (s.rx_st == RX_HUNT) || (s.rx_st == RX_WAIT);
    rx_en = s.ctrl1[C1_EN] && s.ctrl2[C2_RECEIVER_ENABLE];
    tx_en = s.ctrl1[C1_EN] && s.ctrl2[C2_TXEN];
    nbits = s.ctrl1[C1_NINE] ? BITS9 : BITS8;
    status = 8'h00;
    status[ST_TX_BUFFER_EMPTY_FLAG] = s.tx_buffer_empty_flag;
    status[ST_TRANSMITTER_IDLE_FLAG] = s.transmitter_idle_flag;
    status[ST_RX_DATA_READY_FLAG] = s.rx_data_ready_flag;
    status[ST_RECEIVER_IDLE_FLAG] = receiver_idle_flag;
    status[ST_OVERRUN_FLAG] = s.overrun_flag;
    status[ST_NF] = s.nf;
    // error bits travel with the word at the head of the fifo
    status[ST_FRAMING_ERROR_FLAG] = (s.cnt != 2'd0) && head.framing_error_flag;
    status[ST_PARITY_ERROR_FLAG] = (s.cnt != 2'd0) && head.parity_error_flag;
    acc = wb_i.cyc && wb_i.stb && !s.ack;
    wr = acc && wb_i.we && wb_i.sel[0];
    pop = 1'b0;
    push = 1'b0;
    full = 1'b0;
    decide = 1'b0;
    bitv = 1'b0;
    entry = '0;
    tx_end = s.tick && (s.tx_cnt == TICK_LAST);

    // register slave: every access, mapped or not, gets ack on the next edge
    if (acc) begin
      next_s.ack = 1'b1;
      next_s.rdat = 8'h00;
      next_s.seen = (wb_i.adr == ADR_STATUS);
      case (wb_i.adr)
        ADR_STATUS: next_s.rdat = status;
        ADR_CTRL1: begin
          next_s.rdat = s.ctrl1;
          next_s.rdat[C1_RX8] = head.data[8];
          if (wr) begin
            next_s.ctrl1 = wb_i.dat[7:0];
          end
        end
        ADR_CTRL2: begin
          next_s.rdat = s.ctrl2;
          if (wr) begin
            next_s.ctrl2 = wb_i.dat[7:0];
          end
        end
        ADR_BAUD: begin
          next_s.rdat = s.baud;
          if (wr) begin
            next_s.baud = wb_i.dat[7:0];
          end
        end
        ADR_TXDATA: begin
          // a full buffer refuses writes so queued data is never overwritten
          if (wr && s.seen && s.tx_buffer_empty_flag) begin
            next_s.txbuf = {s.ctrl1[C1_TX8], wb_i.dat[7:0]};
            next_s.tx_buffer_empty_flag = 1'b0;
            next_s.transmitter_idle_flag = 1'b0;
          end
        end
        ADR_RXDATA: begin
          if (!wb_i.we) begin
            next_s.rdat = head.data[7:0];
            pop = (s.cnt != 2'd0);
            if (s.seen) begin
              next_s.overrun_flag = 1'b0;
              next_s.nf = 1'b0;
              if (s.cnt <= 2'd1) begin
                next_s.rx_data_ready_flag = 1'b0;
              end
            end
          end
        end
        default: next_s.rdat = 8'h00;
      endcase
    end

    // receiver, stepped by the 16x tick
    if (s.tick) begin
      next_s.rx_smp = {s.rx_smp[1:0], rx_i};
      next_s.rx_cnt = s.rx_cnt + 4'h1;
      bitv = uar_maj3(next_s.rx_smp);
      decide = (s.rx_cnt == TICK_DECIDE);
      if (decide && (next_s.rx_smp != 3'b000) && (next_s.rx_smp != 3'b111)) begin
        next_s.rx_noise = 1'b1;
      end
      unique case (s.rx_st)
        RX_HUNT: begin
          if (rx_en && !rx_i) begin
            next_s.rx_st = RX_START;
            next_s.rx_cnt = 4'h0;
            next_s.rx_bits = 4'h0;
            next_s.rx_noise = 1'b0;
            next_s.rx_framing_error_flag = 1'b0;
            next_s.rx_par = 1'b0;
          end
        end
        RX_START: begin
          // a start bit that votes high was a glitch
          if (decide && bitv) begin
            next_s.rx_st = RX_HUNT;
          end else if (s.rx_cnt == TICK_LAST) begin
            next_s.rx_st = RX_DATA;
          end
        end
        RX_DATA: begin
          if (decide) begin
            next_s.rx_sh = {bitv, s.rx_sh[8:1]};
            next_s.rx_par = s.rx_par ^ bitv;
            next_s.rx_bits = s.rx_bits + 4'h1;
          end
          if ((s.rx_cnt == TICK_LAST) && (s.rx_bits == nbits)) begin
            next_s.rx_st = RX_STOP;
            next_s.rx_bits = 4'h0;
          end
        end
        RX_STOP: begin
          if (decide) begin
            next_s.rx_bits = s.rx_bits + 4'h1;
            if (!bitv) begin
              next_s.rx_framing_error_flag = 1'b1;
            end
            if (s.rx_bits == {3'b000, s.ctrl1[C1_STOP2]}) begin
              push = 1'b1;
              entry.framing_error_flag = s.rx_framing_error_flag || !bitv;
              entry.parity_error_flag = s.ctrl1[C1_PREN] && (s.rx_par ^ s.ctrl1[C1_ODD]);
              entry.data = s.ctrl1[C1_NINE] ? s.rx_sh : {1'b0, s.rx_sh[8:1]};
              next_s.rx_st = next_s.rx_framing_error_flag ? RX_WAIT : RX_HUNT;
            end
          end
        end
        RX_WAIT: begin
          // a held-low break must not pass for the next start bit
          if (bitv) begin
            next_s.rx_st = RX_HUNT;
          end
        end
        default: next_s.rx_st = RX_HUNT;
      endcase
    end

    // fifo: a read in the same cycle makes room for the arriving word
    full = (s.cnt == 2'd2) && !pop;
    if (push) begin
      if (full) begin
        next_s.overrun_flag = 1'b1;
      end else begin
        next_s.fifo[s.wp] = entry;
        next_s.wp = !s.wp;
        next_s.rx_data_ready_flag = 1'b1;
        next_s.nf = next_s.nf | next_s.rx_noise;
      end
      next_s.irq = s.ctrl2[C2_RIE];
    end
    if (pop) begin
      next_s.rp = !s.rp;
    end
    next_s.cnt = s.cnt + {1'b0, push && !full} - {1'b0, pop};

    // transmitter: data frames and break frames
    if (s.tick) begin
      next_s.tx_cnt = s.tx_cnt + 4'h1;
    end
    unique case (s.tx_st)
      TX_IDLE: begin
        next_s.tx_line = 1'b1;
        if (s.tick && tx_en) begin
          if (s.ctrl1[C1_BRK]) begin
            next_s.tx_brk = 1'b1;
            next_s.tx_st = TX_START;
            next_s.tx_cnt = 4'h0;
          end else if (!s.tx_buffer_empty_flag) begin
            next_s.tx_sh = uar_tx_word(s.txbuf, s.ctrl1);
            next_s.tx_brk = 1'b0;
            next_s.tx_buffer_empty_flag = 1'b1;
            next_s.irq = next_s.irq | s.ctrl2[C2_TEIE];
            next_s.tx_st = TX_START;
            next_s.tx_cnt = 4'h0;
          end
        end
      end
      TX_START: begin
        next_s.tx_line = 1'b0;
        if (tx_end) begin
          next_s.tx_st = s.tx_brk ? TX_BRK : TX_DATA;
          next_s.tx_bits = 5'h00;
        end
      end
      TX_DATA: begin
        next_s.tx_line = s.tx_sh[0];
        if (tx_end) begin
          next_s.tx_sh = {1'b0, s.tx_sh[8:1]};
          next_s.tx_bits = s.tx_bits + 5'h01;
          if (s.tx_bits == {1'b0, nbits - 4'h1}) begin
            next_s.tx_st = TX_STOP;
            next_s.tx_bits = 5'h00;
          end
        end
      end
      TX_BRK: begin
        next_s.tx_line = 1'b0;
        if (tx_end) begin
          next_s.tx_bits = s.tx_bits + 5'h01;
          if (s.tx_bits == BREAK_LAST) begin
            next_s.tx_bits = 5'h00;
            if (!s.ctrl1[C1_BRK]) begin
              next_s.tx_st = TX_STOP;
            end
          end
        end
      end
      TX_STOP: begin
        next_s.tx_line = 1'b1;
        if (tx_end) begin
          next_s.tx_bits = s.tx_bits + 5'h01;
          if (s.tx_bits == {4'h0, s.ctrl1[C1_STOP2]}) begin
            next_s.tx_st = TX_IDLE;
            next_s.transmitter_idle_flag = 1'b1;
            next_s.irq = next_s.irq | (s.ctrl2[C2_TIIE] && !s.tx_brk);
          end
        end
      end
      default: next_s.tx_st = TX_IDLE;
    endcase
    if (!tx_en) begin
      next_s.tx_st = TX_IDLE;
      next_s.tx_line = 1'b1;
    end
    if (!rx_en) begin
      next_s.rx_st = RX_HUNT;
    end

    // disabling the port empties the fifo and returns every flag to rest
    if (!next_s.ctrl1[C1_EN]) begin
      next_s.ctrl1[C1_BRK] = 1'b0;
      next_s.ctrl2[C2_TXEN] = 1'b0;
      next_s.ctrl2[C2_RECEIVER_ENABLE] = 1'b0;
      next_s.tx_buffer_empty_flag = 1'b1;
      next_s.transmitter_idle_flag = 1'b1;
      next_s.rx_data_ready_flag = 1'b0;
      next_s.overrun_flag = 1'b0;
      next_s.nf = 1'b0;
      next_s.cnt = 2'd0;
      next_s.wp = 1'b0;
      next_s.rp = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
      s.ctrl1 <= CTRL1_RST;
      s.ctrl2 <= CTRL2_RST;
      s.baud <= BAUD_RST;
      s.tx_buffer_empty_flag <= 1'b1;
      s.transmitter_idle_flag <= 1'b1;
      s.rx_st <= RX_HUNT;
      s.rx_smp <= 3'b111;
      s.tx_st <= TX_IDLE;
      s.tx_line <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign wb_o.ack = s.ack;
  assign wb_o.dat = {24'h000000, s.rdat};
  assign tx_o = s.tx_line;
  assign irq_o = s.irq;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_status_read;
    acc && (wb_i.adr == ADR_STATUS) && !wb_i.we;
  endsequence

  sequence s_data_read_last;
    acc && (wb_i.adr == ADR_RXDATA) && !wb_i.we && (s.cnt == 2'd1) && !push;
  endsequence

  property p_rx_clear;
    s_status_read ##1 s.ack ##[1:2] s_data_read_last |=> !s.rx_data_ready_flag && (s.cnt == 2'd0);
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("data ready not cleared by status then read");

  property p_ack_once;
    acc |=> s.ack ##1 !s.ack;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("bus ack not a single cycle");

  property p_overrun;
    (push && full && s.ctrl2[C2_RIE]) |=> s.overrun_flag && (s.cnt == 2'd2) && irq_o && (s.wp == $past(s.wp));
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun did not keep fifo and flag");

  property p_push_ready;
    (push && !full) |=> s.rx_data_ready_flag && (s.cnt != 2'd0) && (irq_o == $past(s.ctrl2[C2_RIE]));
  endproperty
  a_push_ready: assert property (p_push_ready) else $error("stored word did not raise data ready");

  property p_wait_low;
    (s.rx_st == RX_WAIT) && !rx_i |=> (s.rx_st != RX_START);
  endproperty
  a_wait_low: assert property (p_wait_low) else $error("low line taken as start after bad stop");

  property p_break_len;
    (s.tx_st == TX_BRK) && tx_end && (s.tx_bits == BREAK_LAST) && !s.ctrl1[C1_BRK] |=> (s.tx_st == TX_STOP) ##1 tx_o;
  endproperty
  a_break_len: assert property (p_break_len) else $error("break unit did not end after thirteen bits");

  property p_break_no_irq;
    (s.tx_st == TX_STOP) && s.tx_brk && tx_end |=> !irq_o || $past(push) || $past(s.tx_st) != TX_STOP;
  endproperty
  a_break_no_irq: assert property (p_break_no_irq) else $error("break frame raised transmit interrupt");

  property p_stop_idle;
    (s.rx_st == RX_DATA) |-> !receiver_idle_flag ##0 ($past(s.rx_st) != RX_HUNT);
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("receiver idle high inside a frame");

  property p_framing_error_flag_word;
    push && !full && !bitv |=> s.fifo[$past(s.wp)].framing_error_flag;
  endproperty
  a_framing_error_flag_word: assert property (p_framing_error_flag_word) else $error("low stop bit not stored as framing error");
endmodule

// *** test/uar_remote_tx.sv ***
// behavioural remote serial transmitter that drives the receive line
`timescale 1ns/1ps
module uar_remote_tx #(
  parameter int BIT_CLKS = 32
) (
  input wire logic clk_i,
  output logic line_o
);
  // the line idles high, so a released line reads as a stop level
  initial line_o = 1'b1;

  // a glitch inverts two clocks near the bit centre, hitting one vote only
  task automatic drive_bit(input logic v, input bit gl);
    for (int i = 0; i < BIT_CLKS; i++) begin
      @(posedge clk_i);
      line_o <= (gl && i >= 17 && i < 19) ? ~v : v;
    end
  endtask

  task automatic send(input logic [8:0] d, input int nb, input int sp, input bit bad, input int gl);
    drive_bit(1'b0, 1'b0);
    for (int b = 0; b < nb; b++) begin
      drive_bit(d[b], gl == b);
    end
    for (int s = 0; s < sp; s++) begin
      drive_bit(!(bad && s == sp - 1), 1'b0);
    end
    drive_bit(1'b1, 1'b0);
  endtask

  // a long low followed by a valid stop level
  task automatic brk(input int nbits);
    repeat (nbits) drive_bit(1'b0, 1'b0);
    drive_bit(1'b1, 1'b0);
  endtask
endmodule

// *** test/uar_core_tb.sv ***
// self-checking bench of the receive and break block
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module uar_core_tb;
  import uar_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  uar_wb_req_s wb_i = '0;
  uar_wb_rsp_s wb_o;
  logic rx_line;
  logic tx_o;
  logic irq_o;
  int failures = 0;
  int samples_checked = 0;
  int irqs = 0;
  int irq_exp = 0;
  int seed = 32'he9f4;
  int lo;
  int n;
  logic [7:0] st;
  logic [7:0] v;
  logic [7:0] c1;
  logic [8:0] w [3];

  always #2.5 clk_i = ~clk_i;

  uar_core uut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o), .rx_i(rx_line), .tx_o(tx_o),
    .irq_o(irq_o));
  uar_remote_tx #(.BIT_CLKS(32)) rem (.clk_i(clk_i), .line_o(rx_line));

  always @(posedge clk_i) begin
    if (irq_o === 1'b1) irqs++;
  end

  task automatic summarize;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // the request stands until the rising edge that samples ack high; data is taken there
  task automatic xfer(input logic [4:0] a, input logic we, input logic [7:0] d, output logic [7:0] r);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h1, adr: a, dat: {24'h000000, d}};
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_o.ack !== 1'b1 && k < 20);
    if (k >= 20) failures++;
    r = wb_o.dat[7:0];
    wb_i <= '0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] r;
    xfer(a, 1'b1, d, r);
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] r);
    xfer(a, 1'b0, 8'h00, r);
  endtask

  task automatic pop(output logic [7:0] s, output logic [7:0] d);
    rd(ADR_STATUS, s);
    rd(ADR_RXDATA, d);
  endtask

  task automatic rx_case(input logic [7:0] c, input int nb, input int sp, input bit bad, input int gl);
    logic [8:0] d;
    d = 9'($random(seed));
    if (nb == 8) d[8] = 1'b0;
    wr(ADR_CTRL1, c);
    rem.send(d, nb, sp, bad, gl);
    repeat (40) @(posedge clk_i);
    irq_exp++;
    rd(ADR_CTRL1, c1);
    pop(st, v);
    `CHK(v, d[7:0])
    `CHK(c1[C1_RX8], d[8])
    `CHK(st[ST_FRAMING_ERROR_FLAG], logic'(bad))
    `CHK(st[ST_NF], logic'(gl >= 0))
    `CHK(st[ST_PARITY_ERROR_FLAG], logic'(c[C1_PREN] & ((^d) ^ c[C1_ODD])))
    `CHK(st[ST_RX_DATA_READY_FLAG], 1'b1)
    rd(ADR_STATUS, st);
    `CHK(st & 8'h5f, 8'h0b)
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ADR_STATUS, st);
    `CHK(st, 8'h0b)
    foreach (w[i]) begin
      rd(i == 0 ? ADR_CTRL1 : i == 1 ? ADR_CTRL2 : 5'h18, v);
      `CHK(v, 8'h00)
    end
    wr(ADR_BAUD, 8'h01);
    wr(ADR_CTRL1, 8'h80);
    // a frame before the receiver is enabled must be ignored
    rem.send(9'h0a5, 8, 1, 1'b0, -1);
    rd(ADR_STATUS, st);
    `CHK(st[ST_RX_DATA_READY_FLAG], 1'b0)
    wr(ADR_CTRL2, 8'hc4);
    rx_case(8'h80, 8, 1, 1'b0, -1);
    rx_case(8'hc0, 9, 1, 1'b0, -1);
    rx_case(8'h88, 8, 2, 1'b1, -1);
    rx_case(8'h80, 8, 1, 1'b0, 3);
    rx_case(8'hb0, 8, 1, 1'b0, -1);
    wr(ADR_CTRL1, 8'h80);
    foreach (w[i]) w[i] = 9'($random(seed)) & 9'h0ff;
    fork
      for (int k = 0; k < 3; k++) rem.send(w[k], 8, 1, 1'b0, -1);
      begin
        repeat (200) @(posedge clk_i);
        rd(ADR_STATUS, st);
        `CHK(st[ST_RECEIVER_IDLE_FLAG], 1'b0)
      end
    join
    repeat (40) @(posedge clk_i);
    irq_exp += 3;
    pop(st, v);
    `CHK(st[ST_OVERRUN_FLAG], 1'b1)
    `CHK(v, w[0][7:0])
    pop(st, v);
    `CHK(st[ST_OVERRUN_FLAG], 1'b0)
    `CHK(v, w[1][7:0])
    rd(ADR_STATUS, st);
    `CHK(st[ST_RX_DATA_READY_FLAG], 1'b0)
    rem.brk(25);
    repeat (40) @(posedge clk_i);
    irq_exp++;
    pop(st, v);
    `CHK(st[ST_FRAMING_ERROR_FLAG], 1'b1)
    `CHK(v, 8'h00)
    rd(ADR_STATUS, st);
    `CHK(st[ST_RX_DATA_READY_FLAG] ^ st[ST_RECEIVER_IDLE_FLAG], 1'b1)
    rx_case(8'h80, 8, 1, 1'b0, -1);
    // tx idle interrupt on: a data frame end counts, a break end must not
    wr(ADR_CTRL2, 8'hc6);
    irq_exp++;
    // a data write without a fresh status access is refused
    rd(ADR_CTRL1, c1);
    wr(ADR_TXDATA, 8'h5a);
    rd(ADR_STATUS, st);
    `CHK(st[ST_TRANSMITTER_IDLE_FLAG], 1'b1)
    wr(ADR_TXDATA, 8'h5a);
    rd(ADR_STATUS, st);
    `CHK(st[ST_TRANSMITTER_IDLE_FLAG], 1'b0)
    repeat (14 * 32) @(posedge clk_i);
    wr(ADR_CTRL1, 8'h84);
    n = 0;
    lo = 0;
    while (tx_o !== 1'b0 && n < 2000) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 2000) failures++;
    fork
      while (tx_o === 1'b0 && lo < 4000) begin
        @(negedge clk_i);
        lo++;
      end
      begin
        repeat (640) @(posedge clk_i);
        wr(ADR_CTRL1, 8'h80);
      end
    join
    `CHK(lo % 32, 0)
    `CHK((lo / 32) % 13, 1)
    `CHK(lo >= 27 * 32, 1'b1)
    repeat (96) @(posedge clk_i);
    rd(ADR_STATUS, st);
    `CHK(st[ST_TRANSMITTER_IDLE_FLAG], 1'b1)
    `CHK(tx_o, 1'b1)
    `CHK(irqs, irq_exp)
    summarize();
  end

  // the run needs under ten thousand cycles; four times that means a hang
  initial begin
    repeat (40000) @(posedge clk_i);
    failures++;
    summarize();
  end
endmodule
